//--- asrc_pkg.sv
// Shared constants and types of the asynchronous memory controller.
// Assumes a single 10 MHz clock; every time is a count of clk cycles.
package asrc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int READ_CYCLE_NS = 10;
  localparam int WRITE_CYCLE_NS = 10;
  localparam int ADDR_TO_END_NS = 8;
  localparam int STROBE_OE_LOW_NS = 10;
  localparam int OE_TURNOFF_NS = 5;
  localparam int BYTE_ACCESS_NS = 6;
  localparam int RETENTION_EXIT_NS = 10;
  // Least times round up, and never below one cycle.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_CYC = cyc_up(READ_CYCLE_NS);
  localparam int WRITE_CYC = cyc_up(WRITE_CYCLE_NS);
  localparam int STROBE_CYC = cyc_up(STROBE_OE_LOW_NS);
  localparam int SETUP_CYC = cyc_up(ADDR_TO_END_NS);
  localparam int TURNOFF_CYC = cyc_up(OE_TURNOFF_NS);
  localparam int ACCESS_CYC = cyc_up(BYTE_ACCESS_NS);
  localparam int RECOVER_CYC = cyc_up(RETENTION_EXIT_NS);
  localparam int CNT_W = 4;

  // ==========================================================================
  // Widths and field layout
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam logic [1:0] LANES_OFF = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'h0,
    ASRC_SETUP = 3'h1,
    ASRC_STROBE = 3'h3,
    ASRC_SPACE = 3'h2,
    ASRC_RECOVER = 3'h6
  } asrc_state_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [1:0] laneEn;
    logic [DATA_W-1:0] data;
  } asrc_req_t;

  typedef struct packed {
    logic chipSelect_n;
    logic writeStrobe_n;
    logic outputEnable_n;
    logic high_byte_enable_n;
    logic low_byte_enable_n;
  } asrc_ctl_t;
endpackage

//--- asrc_ctrl.sv
// Controller that drives an asynchronous 256K x 16 static memory.
// Assumes the testbench resolves the data bus from dataOe_n; clk is 10 MHz.
`timescale 1ns/1ns

// Contract
// RL1 - Write is overlap of select, lane, strobe
// RL2 - Data held until strobe edge ends write
// RL3 - Select, address, lanes held before write end
// RL4 - Strobe low long enough with enable low
// RL5 - Do not drive bus before read turnoff
// RL6 - Keep output enable high when writing
// RL7 - Memory floats pins when deselected
// RL8 - No drive during output enable turnoff
// RL9 - Address valid before select falls
// RL10 - Address-paced reads give fresh data
// RL11 - Lane access and release times met
// RL12 - Memory floats pins while strobe low
// RL13 - Strobe pulse width met in lane writes
// RL14 - Wait one read cycle after retention
// RL15 - Each enabled lane stores its byte
// RL16 - Reads drive only enabled lanes
// RL17 - Space accesses by one cycle time
module asrc_ctrl
  import asrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire asrc_pkg::asrc_req_t req,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic retentionExit,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic [ADDR_W-1:0] memAddr,
  output asrc_pkg::asrc_ctl_t memCtl,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe_n,
  input wire logic [DATA_W-1:0] dataIn
);
  import asrc_pkg::*;

  // Every assertion below samples on clk and rests while reset is low.
  default clocking assertClk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // State
  asrc_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic write_r;
  logic [1:0] lanes_r;
  logic [DATA_W-1:0] inSync1_r;
  logic [DATA_W-1:0] inSync2_r;
  logic accept;

  assign accept = reqValid && reqReady;

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inSync1_r <= '0;
      inSync2_r <= '0;
    end else begin
      inSync1_r <= dataIn;
      inSync2_r <= inSync1_r;
    end
  end

  // Sequencer: setup, strobe, spacing, and post-retention recovery.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ASRC_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        ASRC_IDLE: begin
          if (retentionExit) begin
            state_r <= ASRC_RECOVER;
            cnt_r <= CNT_W'(RECOVER_CYC); // RL14
          end else if (accept) begin
            state_r <= ASRC_SETUP; // RL9
            cnt_r <= CNT_W'(SETUP_CYC); // RL3
          end
        end
        ASRC_SETUP: begin
          if (cnt_r <= CNT_W'(1)) begin
            state_r <= ASRC_STROBE;
            // A write adds one hold cycle so the strobe rises before select.
            cnt_r <= write_r ? CNT_W'(STROBE_CYC + 1) // RL4 RL13 RL2
                             : CNT_W'(ACCESS_CYC + 2); // RL11
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        ASRC_STROBE: begin
          if (cnt_r <= CNT_W'(1)) begin
            state_r <= ASRC_SPACE;
            cnt_r <= write_r ? CNT_W'(WRITE_CYC) // RL17
                             : CNT_W'(READ_CYC + TURNOFF_CYC); // RL8
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        ASRC_SPACE, ASRC_RECOVER: begin
          if (cnt_r <= CNT_W'(1)) begin
            state_r <= ASRC_IDLE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        default: begin
          state_r <= ASRC_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Request capture: address, lanes and write data stay put for the access.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_r <= 1'b0;
      lanes_r <= '0;
      memAddr <= '0;
      dataOut <= '0;
    end else if (accept && state_r == ASRC_IDLE && !retentionExit) begin
      write_r <= req.write;
      lanes_r <= req.laneEn; // RL15 RL16
      memAddr <= req.addr; // RL9 RL10
      dataOut <= req.data; // RL2
    end
  end

  // Memory pins: output enable is only ever low in a read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memCtl <= '1;
      dataOe_n <= 1'b1;
    end else begin
      memCtl <= '1;
      dataOe_n <= 1'b1;
      if (state_r == ASRC_SETUP || state_r == ASRC_STROBE) begin
        memCtl.chipSelect_n <= 1'b0;
        memCtl.high_byte_enable_n <= ~lanes_r[1];
        memCtl.low_byte_enable_n <= ~lanes_r[0];
        memCtl.outputEnable_n <= write_r; // RL6
        // Strobe falls after setup, rises with the strobe phase end.
        memCtl.writeStrobe_n <= !(write_r && state_r == ASRC_STROBE &&
                                  cnt_r > CNT_W'(1)); // RL1
        dataOe_n <= !write_r; // RL5
      end
    end
  end

  // Read data is taken at the end of the strobe phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
      rdValid <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      if (state_r == ASRC_STROBE && cnt_r <= CNT_W'(1) && !write_r) begin
        rdData <= inSync2_r; // RL11
        rdValid <= 1'b1;
      end
    end
  end

  // Ready only while idle and not recovering.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state_r == ASRC_IDLE) && !accept && !retentionExit;
    end
  end

  // ==========================================================================
  // Assertions
  // Write overlap: the strobe only falls inside a selected, driven access.
  writeOverlap_a: assert property (!memCtl.writeStrobe_n |-> // RL1
    !memCtl.chipSelect_n && !dataOe_n)
    else $error("strobe low without select or data drive");
  dataHeld_a: assert property ($rose(memCtl.writeStrobe_n) |-> // RL2
    !dataOe_n && $stable(dataOut))
    else $error("data not held at write end");
  // Select, address and lanes are all in place before the strobe moves.
  selBeforeEnd_a: assert property ($fell(memCtl.writeStrobe_n) |-> // RL3
    !$past(memCtl.chipSelect_n))
    else $error("select not set up before strobe");
  laneHeld_a: assert property (!memCtl.writeStrobe_n |-> // RL3
    $stable(memAddr) && $stable(memCtl.low_byte_enable_n) &&
    $stable(memCtl.high_byte_enable_n))
    else $error("address or lanes moved in write");
  // The data bus has one owner: output enable is low only in a read.
  oeHighWrite_a: assert property (!dataOe_n |-> // RL6 RL5
    memCtl.outputEnable_n)
    else $error("output enable low while driving");
  readQuiet_a: assert property (!memCtl.outputEnable_n |-> // RL5 RL6
    dataOe_n && memCtl.writeStrobe_n)
    else $error("bus driven or strobe low in read");
  addrStable_a: assert property (!memCtl.chipSelect_n |-> // RL9
    $stable(memAddr))
    else $error("address moved while selected");
  // A write strobe is one low cycle and rises while select and data hold.
  sequence strobeLow_s;
    $fell(memCtl.writeStrobe_n);
  endsequence
  sequence strobeEnd_s;
    memCtl.writeStrobe_n && !memCtl.chipSelect_n && !dataOe_n;
  endsequence
  strobeWidth_a: assert property (strobeLow_s |-> // RL4 RL13
    !memCtl.writeStrobe_n [*1] ##1 strobeEnd_s)
    else $error("strobe pulse of wrong length");
  // After output enable rises the bus stays free for the turn-off time.
  turnoffGap_a: assert property ($rose(memCtl.outputEnable_n) |-> // RL8
    dataOe_n [*2])
    else $error("bus driven during turnoff");
  // Read data is taken only after the access time and two sync stages.
  readAccess_a: assert property (rdValid |-> // RL11
    !$past(memCtl.outputEnable_n, 3))
    else $error("read data taken too early");
  recoverWait_a: assert property (state_r == ASRC_IDLE && // RL14
    retentionExit |=> !reqReady [*2])
    else $error("access before recovery");
  // Successive accesses leave select high for at least the cycle time.
  spacing_a: assert property ($rose(memCtl.chipSelect_n) |-> // RL17
    memCtl.chipSelect_n [*2])
    else $error("accesses not spaced");
endmodule

//--- asrc_mem_model.sv
// Behavioural model of the 256K x 16 asynchronous static memory.
// Assumes the bench resolves the shared data bus from laneDrv.
`timescale 1ns/1ns
module asrc_mem_model
  import asrc_pkg::*;
(
  input wire logic [ADDR_W-1:0] memAddr,
  input wire asrc_pkg::asrc_ctl_t memCtl,
  input wire logic [DATA_W-1:0] busIn,
  output logic [DATA_W-1:0] rdQ,
  output logic [1:0] laneDrv
);
  import asrc_pkg::*;
  // ==========================================================================
  // Storage
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  logic wrOn;
  // A write is the overlap of select, a lane and the strobe.
  assign wrOn = !memCtl.chipSelect_n && !memCtl.writeStrobe_n &&
    !(memCtl.low_byte_enable_n && memCtl.high_byte_enable_n);
  // Each enabled lane stores its byte when the overlap ends.
  always @(negedge wrOn) begin
    if (!memCtl.low_byte_enable_n) cells[memAddr][7:0] = busIn[7:0];
    if (!memCtl.high_byte_enable_n) cells[memAddr][15:8] = busIn[15:8];
  end
  // A lane drives only when selected, reading, enabled and output on.
  assign laneDrv[0] = !memCtl.chipSelect_n && memCtl.writeStrobe_n &&
    !memCtl.outputEnable_n && !memCtl.low_byte_enable_n;
  assign laneDrv[1] = !memCtl.chipSelect_n && memCtl.writeStrobe_n &&
    !memCtl.outputEnable_n && !memCtl.high_byte_enable_n;
  // Data follows the address with no further strobe.
  assign rdQ = cells[memAddr];
endmodule

//--- async_sram_cycle_timing_test.sv
// Self-checking bench of the memory controller against the memory model.
// Assumes a 10 MHz clock; floating lanes show the inverse of the cell.
`timescale 1ns/1ns
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin numErrors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module async_sram_cycle_timing_test;
  import asrc_pkg::*;
  logic clk, rst_n, reqValid, reqReady, retentionExit, rdValid, dataOe_n;
  asrc_req_t req;
  asrc_ctl_t memCtl;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] rdData, dataOut, dataIn, rdQ, q;
  logic [1:0] laneDrv;
  int numErrors = 0;
  int checks = 0;
  // ==========================================================================
  // Harness
  asrc_ctrl dut (.clk(clk), .rst_n(rst_n), .req(req), .reqValid(reqValid),
    .reqReady(reqReady), .retentionExit(retentionExit), .rdData(rdData),
    .rdValid(rdValid), .memAddr(memAddr), .memCtl(memCtl),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn));
  asrc_mem_model mem (.memAddr(memAddr), .memCtl(memCtl), .busIn(dataIn),
    .rdQ(rdQ), .laneDrv(laneDrv));
  // The bus is the controller's data when it drives, else each lane.
  assign dataIn = !dataOe_n ? dataOut :
    {laneDrv[1] ? rdQ[15:8] : ~rdQ[15:8], laneDrv[0] ? rdQ[7:0] : ~rdQ[7:0]};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Bus ownership is checked at every falling edge once out of reset.
  always @(negedge clk) if (rst_n) begin
    `CHK(!dataOe_n && |laneDrv, 1'b0, "bus driven by both")
    if (!memCtl.writeStrobe_n) begin
      `CHK(memCtl.outputEnable_n, 1'b1, "output on in write")
      `CHK(dataOe_n, 1'b0, "write data not driven")
    end
  end
  // One access; returns one step after the edge after rdValid rises for a read, or after the edge after a write is taken.
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
      input logic [1:0] ln, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req = '{write: w, addr: a, laneEn: ln, data: d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    @(posedge clk);
    #1 reqValid = 1'b0;
    n = 0;
    while (!w && rdValid !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    q = rdData;
    `CHK(n < 50, 1'b1, "no answer")
    // Let an edge pass so the next call never re-raises valid at once.
    @(posedge clk);
    #1;
  endtask
  task automatic test_reset();
    `CHK(memCtl, 5'h1F, "controls not idle")
    `CHK(dataOe_n, 1'b1, "bus driven in reset")
    $display("test_reset done");
  endtask
  task automatic test_words();
    logic [ADDR_W-1:0] ad [3] = '{18'h0_0000, 18'h0_0005, 18'h3_FFFF};
    logic [DATA_W-1:0] dv [3] = '{16'hA5C3, 16'h0001, 16'h8000};
    for (int i = 0; i < 3; i++) access(1'b1, ad[i], 2'h3, dv[i]);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, ad[i], 2'h3, 16'h0000);
      `CHK(q, dv[i], "word read back")
    end
    $display("test_words done");
  endtask
  task automatic test_lanes();
    access(1'b1, 18'h0_1234, 2'h3, 16'h1111);
    access(1'b1, 18'h0_1234, 2'h1, 16'hEE22);
    access(1'b1, 18'h0_1234, 2'h2, 16'h33DD);
    access(1'b1, 18'h0_1234, 2'h0, 16'hFFFF);
    access(1'b0, 18'h0_1234, 2'h3, 16'h0000);
    `CHK(q, 16'h3322, "lane merge")
    access(1'b0, 18'h0_1234, 2'h1, 16'h0000);
    `CHK(q[7:0], 8'h22, "low lane read")
    `CHK(q[15:8], 8'hCC, "high lane not floated")
    $display("test_lanes done");
  endtask
  task automatic test_retention();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
    retentionExit = 1'b1;
    @(posedge clk);
    #1 retentionExit = 1'b0;
    `CHK(reqReady, 1'b0, "taken while recovering")
    @(posedge clk);
    #1;
    `CHK(reqReady, 1'b0, "recovery too short")
    access(1'b0, 18'h0_0005, 2'h3, 16'h0000);
    `CHK(q, 16'h0001, "read after recovery")
    $display("test_retention done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    retentionExit = 1'b0;
    req = '0;
    repeat (11) @(posedge clk);
    #1 test_reset();
    @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 test_words();
    test_lanes();
    test_retention();
    print_verdict();
  end
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    #400000;
    numErrors++;
    print_verdict();
  end
endmodule
